/* File: design/frr_out_fifo.sv */
`timescale 1ns/100ps
// Purpose: small output buffer for words leaving the memory
// Assumes: depth is a power of two
// Notes:   full stalls the reader through in_ready
module frr_out_fifo #(
    parameter int W     = 36,
    parameter int DEPTH = 4
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_resetn,
    frr_stream_if.buf_side    s
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [PW:0]  wp_q;
    logic [PW:0]  rp_q;
    wire          push = s.in_valid & s.in_ready;
    wire          pop  = s.out_valid & s.out_ready;
    wire [PW:0]   used = wp_q - rp_q;

    assign s.in_ready  = (used != (PW+1)'(DEPTH));
    assign s.out_valid = (used != '0);
    assign s.out_data  = mem_q[rp_q[PW-1:0]];

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop)  rp_q <= rp_q + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (push) mem_q[wp_q[PW-1:0]] <= s.in_data;
    end
endmodule

/* File: design/frr_pkg.sv */
// Purpose: constants for the fifo read, rewind and serial offset block
// Assumes: one clock, synchronous active-low reset
// Notes:   register offsets are byte addresses on the register bus
//
// Operation
// - synchronous reads happen only while gate enabled
// - rewind request moves read pointer to zero
// - rewind shows empty or clears output-valid
// - rewind keeps write pointer, modes, offsets
// - rewind goes to marked position when set
// - offset shift clock shifts serial bit in
// - serial offset load only while gate active
package frr_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] FRR_REG_CTRL   = 8'h00;
    localparam logic [7:0] FRR_REG_STATUS = 8'h04;
    localparam logic [7:0] FRR_REG_AE_OFS = 8'h08;
    localparam logic [7:0] FRR_REG_AF_OFS = 8'h0C;
    localparam logic [7:0] FRR_REG_RD_PTR = 8'h10;
    localparam logic [7:0] FRR_REG_WR_PTR = 8'h14;

    localparam int FRR_CTRL_ASYNC  = 0;
    localparam int FRR_CTRL_LOOKAH = 1;
    localparam int FRR_CTRL_SERIAL = 2;
    localparam int FRR_CTRL_W      = 3;
    localparam logic [2:0] FRR_CTRL_RST = 3'h0;

    localparam int FRR_ST_EMPTY = 0;
    localparam int FRR_ST_FULL  = 1;
    localparam int FRR_ST_MARK  = 2;
    localparam int FRR_ST_CNT   = 8;

    localparam logic [1:0] FRR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] FRR_RESP_SLVERR = 2'h2;

    // ****************************************
    // pin bank indices, all synchronised
    // ****************************************
    localparam int FRR_PIN_GATE_N = 0;
    localparam int FRR_PIN_STROBE = 1;
    localparam int FRR_PIN_REWIND = 2;
    localparam int FRR_PIN_MARK   = 3;
    localparam int FRR_PIN_SCLK   = 4;
    localparam int FRR_PIN_SGATE  = 5;
    localparam int FRR_PIN_SI     = 6;
    localparam int FRR_PIN_N      = 7;
    localparam logic [6:0] FRR_PIN_RST = 7'h01;

    localparam int FRR_MEM_AW    = 19;
    localparam int FRR_DATA_W    = 36;
    localparam int FRR_OUT_DEPTH = 4;
endpackage

/* File: design/frr_read_ctrl.sv */
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Purpose: fifo memory read side with rewind, mark and serial offsets
// Assumes: pins come from another domain and are synchronised here
// Notes:   registers over AXI4-Lite, one word per register
module frr_read_ctrl
    import frr_pkg::*;
#(
    parameter int AW = FRR_MEM_AW,
    parameter int DW = FRR_DATA_W,
    parameter int OD = FRR_OUT_DEPTH
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_resetn,
    // write port from the write side of the memory
    input  wire logic          i_wr_valid,
    input  wire logic [DW-1:0] i_wr_data,
    output logic               o_wr_ready,
    // read-side pins
    input  wire logic          i_read_gate_n,
    input  wire logic          i_read_strobe,
    input  wire logic          i_rewind_request,
    input  wire logic          i_mark,
    input  wire logic          i_offset_shift_clk,
    input  wire logic          i_offset_shift_gate,
    input  wire logic          i_offset_serial,
    // read data stream
    output logic               o_rd_valid,
    output logic [DW-1:0]      o_rd_data,
    input  wire logic          i_rd_ready,
    // flags
    output logic               o_empty_indicator_n,
    output logic               o_output_valid_n,
    output logic               o_almost_empty_n,
    output logic               o_almost_full_n,
    // AXI4-Lite slave
    input  wire logic [7:0]    i_s_axi_awaddr,
    input  wire logic          i_s_axi_awvalid,
    output logic               o_s_axi_awready,
    input  wire logic [31:0]   i_s_axi_wdata,
    input  wire logic [3:0]    i_s_axi_wstrb,
    input  wire logic          i_s_axi_wvalid,
    output logic               o_s_axi_wready,
    output logic [1:0]         o_s_axi_bresp,
    output logic               o_s_axi_bvalid,
    input  wire logic          i_s_axi_bready,
    input  wire logic [7:0]    i_s_axi_araddr,
    input  wire logic          i_s_axi_arvalid,
    output logic               o_s_axi_arready,
    output logic [31:0]        o_s_axi_rdata,
    output logic [1:0]         o_s_axi_rresp,
    output logic               o_s_axi_rvalid,
    input  wire logic          i_s_axi_rready
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [FRR_PIN_N-1:0] p1_q;
    logic [FRR_PIN_N-1:0] p2_q;
    logic [FRR_PIN_N-1:0] p3_q;
    wire  [FRR_PIN_N-1:0] pins = {i_offset_serial, i_offset_shift_gate,
        i_offset_shift_clk, i_mark, i_rewind_request, i_read_strobe,
        i_read_gate_n};

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            p1_q <= FRR_PIN_RST;
            p2_q <= FRR_PIN_RST;
            p3_q <= FRR_PIN_RST;
        end else begin
            p1_q <= pins;
            p2_q <= p1_q;
            p3_q <= p2_q;
        end
    end

    wire gate_n = p2_q[FRR_PIN_GATE_N];
    wire rew    = p2_q[FRR_PIN_REWIND];
    wire mark   = p2_q[FRR_PIN_MARK];
    wire sgate  = p2_q[FRR_PIN_SGATE];
    wire sbit   = p2_q[FRR_PIN_SI];
    wire strb_e = p2_q[FRR_PIN_STROBE] & ~p3_q[FRR_PIN_STROBE];
    wire sclk_e = p2_q[FRR_PIN_SCLK] & ~p3_q[FRR_PIN_SCLK];
    wire mark_e = mark & ~p3_q[FRR_PIN_MARK];

    // ****************************************
    // state
    // ****************************************
    logic [FRR_CTRL_W-1:0] ctrl_q;
    logic [AW-1:0]         ae_ofs_q;
    logic [AW-1:0]         af_ofs_q;
    logic [AW-1:0]         rd_ptr_q;
    logic [AW-1:0]         wr_ptr_q;
    logic [AW-1:0]         mark_ptr_q;
    logic                  mark_vld_q;
    logic [AW:0]           cnt_q;
    logic                  empty_n_q;
    logic                  ovld_n_q;
    logic [DW-1:0]         mem_q [2**AW];

    wire async_rd = ctrl_q[FRR_CTRL_ASYNC];
    wire lookah   = ctrl_q[FRR_CTRL_LOOKAH];
    wire full     = cnt_q[AW];
    wire empty    = (cnt_q == '0);

    frr_stream_if #(.W(DW)) ob ();

    frr_out_fifo #(.W(DW), .DEPTH(OD)) u_out (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .s         (ob)
    );

    wire rd_req  = async_rd ? strb_e : ~gate_n;
    wire rd_pop  = rd_req & ~empty & ob.in_ready & ~rew;
    wire wr_push = i_wr_valid & ~full;
    wire [AW-1:0] rew_ptr  = mark_vld_q ? mark_ptr_q : '0;
    wire [AW-1:0] rew_dist = wr_ptr_q - rew_ptr;

    assign o_wr_ready    = ~full;
    assign ob.in_valid   = rd_pop;
    assign ob.in_data    = mem_q[rd_ptr_q];
    assign ob.out_ready  = i_rd_ready;
    assign o_rd_valid    = ob.out_valid;
    assign o_rd_data     = ob.out_data;
    assign o_empty_indicator_n = lookah ? 1'b1 : empty_n_q;
    assign o_output_valid_n    = lookah ? ovld_n_q : 1'b1;

    function automatic logic [AW:0] next_cnt(input logic [AW:0] c,
                                             input logic p,
                                             input logic q);
        next_cnt = c + (AW+1)'(p) - (AW+1)'(q);
    endfunction

    wire [AW:0] cnt_d = rew ? {1'b0, rew_dist} + (AW+1)'(wr_push)
                            : next_cnt(cnt_q, wr_push, rd_pop);

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            rd_ptr_q <= '0;
            wr_ptr_q <= '0;
            cnt_q    <= '0;
        end else begin
            if (rew) rd_ptr_q <= rew_ptr;
            else if (rd_pop) rd_ptr_q <= rd_ptr_q + 1'b1;
            if (wr_push) wr_ptr_q <= wr_ptr_q + 1'b1;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (wr_push) mem_q[wr_ptr_q] <= i_wr_data;
    end

    // marks are taken on the rising mark pin, dropped when it falls
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            mark_ptr_q <= '0;
            mark_vld_q <= 1'b0;
        end else begin
            if (mark_e) mark_ptr_q <= rd_ptr_q;
            mark_vld_q <= mark;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            empty_n_q <= 1'b0;
            ovld_n_q  <= 1'b1;
        end else begin
            empty_n_q <= ~rew & (cnt_d != '0);
            ovld_n_q  <= rew | (cnt_d == '0);
        end
    end

    wire [AW:0] depth = (AW+1)'(2**AW);
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_almost_empty_n <= 1'b0;
            o_almost_full_n  <= 1'b1;
        end else begin
            o_almost_empty_n <= cnt_d > {1'b0, ae_ofs_q};
            o_almost_full_n  <= cnt_d < depth - {1'b0, af_ofs_q};
        end
    end

    // ****************************************
    // register bus
    // ****************************************
    logic       aw_have_q;
    logic       w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    assign o_s_axi_awready = ~aw_have_q & ~o_s_axi_bvalid;
    assign o_s_axi_wready  = ~w_have_q & ~o_s_axi_bvalid;
    assign o_s_axi_arready = ~o_s_axi_rvalid;

    wire do_wr  = aw_have_q & w_have_q & ~o_s_axi_bvalid;
    wire wr_all = (wstrb_q == 4'hF);
    wire wr_ctl = do_wr & wr_all & (awaddr_q == FRR_REG_CTRL);
    wire wr_ae  = do_wr & wr_all & (awaddr_q == FRR_REG_AE_OFS);
    wire wr_af  = do_wr & wr_all & (awaddr_q == FRR_REG_AF_OFS);
    wire wr_hit = (awaddr_q == FRR_REG_CTRL) | (awaddr_q == FRR_REG_AE_OFS)
                | (awaddr_q == FRR_REG_AF_OFS);

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            aw_have_q      <= 1'b0;
            w_have_q       <= 1'b0;
            awaddr_q       <= '0;
            wdata_q        <= '0;
            wstrb_q        <= '0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= FRR_RESP_OKAY;
        end else begin
            if (i_s_axi_awvalid & o_s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= i_s_axi_awaddr;
            end
            if (i_s_axi_wvalid & o_s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= i_s_axi_wdata;
                wstrb_q  <= i_s_axi_wstrb;
            end
            if (do_wr) begin
                aw_have_q      <= 1'b0;
                w_have_q       <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp  <= wr_hit ? FRR_RESP_OKAY : FRR_RESP_SLVERR;
            end else if (i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire sh_go = sclk_e & sgate;
    wire [2*AW-1:0] chain = {ae_ofs_q, af_ofs_q};
    wire [2*AW-1:0] chain_sh = {chain[2*AW-2:0], sbit};

    // a bus write wins over a shift landing in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            ctrl_q   <= FRR_CTRL_RST;
            ae_ofs_q <= '0;
            af_ofs_q <= '0;
        end else begin
            if (wr_ctl) ctrl_q <= wdata_q[FRR_CTRL_W-1:0];
            if (sh_go & ~wr_ae & ~wr_af) begin
                ae_ofs_q <= chain_sh[2*AW-1:AW];
                af_ofs_q <= chain_sh[AW-1:0];
            end else begin
                if (wr_ae) ae_ofs_q <= wdata_q[AW-1:0];
                if (wr_af) af_ofs_q <= wdata_q[AW-1:0];
            end
        end
    end

    logic [31:0] rd_word;
    always_comb begin
        rd_word = '0;
        case (i_s_axi_araddr)
            FRR_REG_CTRL:   rd_word[FRR_CTRL_W-1:0] = ctrl_q;
            FRR_REG_STATUS: begin
                rd_word[FRR_ST_EMPTY] = empty;
                rd_word[FRR_ST_FULL]  = full;
                rd_word[FRR_ST_MARK]  = mark_vld_q;
                rd_word[FRR_ST_CNT +: AW+1] = cnt_q;
            end
            FRR_REG_AE_OFS: rd_word[AW-1:0] = ae_ofs_q;
            FRR_REG_AF_OFS: rd_word[AW-1:0] = af_ofs_q;
            FRR_REG_RD_PTR: rd_word[AW-1:0] = rd_ptr_q;
            FRR_REG_WR_PTR: rd_word[AW-1:0] = wr_ptr_q;
            default:        rd_word = '0;
        endcase
    end
    wire rd_hit = (i_s_axi_araddr <= FRR_REG_WR_PTR)
                & (i_s_axi_araddr[1:0] == 2'h0);

    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= '0;
            o_s_axi_rresp  <= FRR_RESP_OKAY;
        end else if (i_s_axi_arvalid & o_s_axi_arready) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata  <= rd_word;
            o_s_axi_rresp  <= rd_hit ? FRR_RESP_OKAY : FRR_RESP_SLVERR;
        end else if (i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    AST_GATE_HOLD: assert property (
        (!async_rd && gate_n && !rew) |=> rd_ptr_q == $past(rd_ptr_q))
        else $error("read pointer moved with read gate off");
    AST_REWIND_ZERO: assert property (
        (rew && !mark_vld_q) |=> rd_ptr_q == '0)
        else $error("rewind did not reach zero");
    AST_REWIND_EMPTY: assert property (
        (rew && !lookah && !wr_ctl) |=> !o_empty_indicator_n)
        else $error("empty indicator not low after rewind");
    AST_REWIND_OVLD: assert property (
        (rew && lookah && !wr_ctl) |=> o_output_valid_n)
        else $error("output valid flag not high after rewind");
    AST_REWIND_KEEP: assert property (
        (rew && !wr_push && !do_wr && !sh_go) |=>
        $stable(wr_ptr_q) && $stable(ctrl_q) && $stable(ae_ofs_q)
        && $stable(af_ofs_q))
        else $error("rewind disturbed write side or settings");
    AST_REWIND_MARK: assert property (
        (rew && mark_vld_q) |=> rd_ptr_q == $past(mark_ptr_q))
        else $error("rewind missed marked position");
    AST_SHIFT_IN: assert property (
        (sclk_e && sgate && !do_wr) |=> af_ofs_q[0] == $past(sbit)
        && ae_ofs_q[0] == $past(af_ofs_q[AW-1]))
        else $error("serial bit not shifted in");
    AST_SHIFT_GATED: assert property (
        (!sgate && !do_wr) |=> $stable(ae_ofs_q) && $stable(af_ofs_q))
        else $error("offsets changed with shift gate off");
    AST_SCLK_IGNORED: assert property (
        (sclk_e && !sgate && !wr_ae && !wr_af) |=>
        $stable({ae_ofs_q, af_ofs_q}))
        else $error("shift clock not ignored");

    COV_REWIND_MARK: cover property (rew && mark_vld_q);
    COV_SERIAL: cover property (sh_go ##1 sh_go);
    COV_STALL: cover property (rd_req && !empty && !ob.in_ready);
endmodule

/* File: design/frr_stream_if.sv */
`timescale 1ns/100ps
// Purpose: valid/ready word stream between block modules
// Assumes: single clock
// Notes:   fill side is the producer, drain side the consumer
interface frr_stream_if #(parameter int W = 36);
    logic         in_valid;
    logic         in_ready;
    logic [W-1:0] in_data;
    logic         out_valid;
    logic         out_ready;
    logic [W-1:0] out_data;
    modport buf_side (input in_valid, input in_data, output in_ready,
                      output out_valid, output out_data, input out_ready);
    modport user_side (output in_valid, output in_data, input in_ready,
                       input out_valid, input out_data, output out_ready);
endinterface

/* File: tb/frr_host_model.sv */
`timescale 1ns/100ps
// Purpose: host logic that drives the read-side pins and drains words
// Assumes: one clock, every pin changed just after a rising edge
// Notes:   shift clock stands low outside a load; strobe and shift clock phases last 3 cycles, a rewind request 1
module frr_host_model #(
    parameter int DW = 36
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rd_valid,
    input  wire logic [DW-1:0] i_rd_data,
    output logic               o_rd_ready,
    output logic               o_read_gate_n,
    output logic               o_read_strobe,
    output logic               o_rewind_request,
    output logic               o_mark,
    output logic               o_offset_shift_clk,
    output logic               o_offset_shift_gate,
    output logic               o_offset_serial
);
    logic [DW-1:0] got_q[$];
    logic          stall;

    initial begin
        o_rd_ready = 1'b0;
        o_read_gate_n = 1'b1;
        o_read_strobe = 1'b0;
        o_rewind_request = 1'b0;
        o_mark = 1'b0;
        o_offset_shift_clk = 1'b0;
        o_offset_shift_gate = 1'b0;
        o_offset_serial = 1'b0;
        stall = 1'b0;
    end

    // ****************************************
    // consumer, stalls on request
    // ****************************************
    always @(posedge i_sys_clk) begin
        if (i_rd_valid && o_rd_ready) got_q.push_back(i_rd_data);
        o_rd_ready <= !stall;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask

    // gate held low by caller in async mode
    task automatic gate(input logic on);
        o_read_gate_n <= !on;
        hold(1);
    endtask

    task automatic strobe();
        o_read_strobe <= 1'b1;
        hold(3);
        o_read_strobe <= 1'b0;
        hold(3);
    endtask

    // one cycle high gives exactly one rewind
    task automatic rewind();
        o_rewind_request <= 1'b1;
        hold(1);
        o_rewind_request <= 1'b0;
    endtask

    // data line shows the inverse once its bit has been taken
    task automatic shift(input logic b, input logic g);
        o_offset_shift_gate <= g;
        o_offset_serial <= b;
        hold(3);
        o_offset_shift_clk <= 1'b1;
        hold(3);
        o_offset_shift_clk <= 1'b0;
        o_offset_serial <= !b;
        hold(3);
        o_offset_shift_gate <= 1'b0;
        hold(1);
    endtask
endmodule

/* File: tb/test_fifo_read_retransmit_offset_load.sv */
`timescale 1ns/100ps
// Purpose: self-checking bench for the fifo read, rewind and offset block
// Assumes: memory shortened to 16 words, host model on the read side
// Notes:   registers reached over AXI4-Lite
module test_fifo_read_retransmit_offset_load
    import frr_pkg::*;
;
    localparam logic [35:0] BASE = 36'h1_0000_0000;
    logic        sys_clk = 1'b0;
    logic        resetn, wr_valid, wr_ready, rd_valid, rd_ready;
    logic        empty_n, ov_n, lo, hi, ae_n, af_n;
    logic [35:0] wr_data, rd_data;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    logic        gate_n, strobe, rewind, mark, sclk, sgate, sdata;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          words = 0;

    always #20 sys_clk = ~sys_clk;

    frr_read_ctrl #(.AW(4)) dut_u (
        .i_sys_clk(sys_clk), .i_resetn(resetn), .i_wr_valid(wr_valid),
        .i_wr_data(wr_data), .o_wr_ready(wr_ready), .i_read_gate_n(gate_n),
        .i_read_strobe(strobe), .i_rewind_request(rewind), .i_mark(mark),
        .i_offset_shift_clk(sclk), .i_offset_shift_gate(sgate),
        .i_offset_serial(sdata), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
        .i_rd_ready(rd_ready), .o_empty_indicator_n(empty_n),
        .o_output_valid_n(ov_n), .o_almost_empty_n(ae_n),
        .o_almost_full_n(af_n),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
        .i_s_axi_rready(rready));

    frr_host_model #(.DW(36)) host_u (
        .i_sys_clk(sys_clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
        .o_rd_ready(rd_ready), .o_read_gate_n(gate_n),
        .o_read_strobe(strobe), .o_rewind_request(rewind), .o_mark(mark),
        .o_offset_shift_clk(sclk), .o_offset_shift_gate(sgate),
        .o_offset_serial(sdata));

    // ****************************************
    // checks, bus cycles and stream helpers
    // ****************************************
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // a hang ends here; the full run needs a few hundred cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                chk(bresp, er);
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                chk(rdata, ed);
                chk(rresp, er);
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic push(input int n);
        @(posedge sys_clk);
        wr_valid <= 1'b1;
        wr_data <= BASE + words;
        while (n > 0) begin
            @(posedge sys_clk);
            if (wr_ready) begin
                words++;
                n--;
                wr_data <= BASE + words;
            end
        end
        wr_valid <= 1'b0;
    endtask

    // waits for n words, then compares them with words first.. in order
    task automatic got(input int first, input int n);
        repeat (400) if (host_u.got_q.size() < n) @(posedge sys_clk);
        chk(host_u.got_q.size(), n);
        for (int i = 0; i < n && i < host_u.got_q.size(); i++) begin
            chk(host_u.got_q[i], BASE + first + i);
        end
        host_u.got_q.delete();
    endtask

    task automatic rewind_watch();
        lo = 1'b0;
        hi = 1'b0;
        host_u.rewind();
        repeat (6) begin
            @(posedge sys_clk);
            if (empty_n === 1'b0) lo = 1'b1;
            if (ov_n === 1'b1) hi = 1'b1;
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        resetn = 1'b0;
        wr_valid = 1'b0;
        wr_data = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(FRR_REG_CTRL, 32'h0000_0000, FRR_RESP_OKAY);
        rd(FRR_REG_STATUS, 32'h0000_0001, FRR_RESP_OKAY);
        rd(8'h18, 32'h0000_0000, FRR_RESP_SLVERR);
        wr(FRR_REG_RD_PTR, 32'h0000_0001, FRR_RESP_SLVERR);
        wr(FRR_REG_AE_OFS, 32'h0000_0003, FRR_RESP_OKAY);
        push(3);
        host_u.hold(12);
        chk(host_u.got_q.size(), 0);
        host_u.gate(1'b1);
        got(0, 3);
        host_u.gate(1'b0);
        rd(FRR_REG_RD_PTR, 32'h0000_0003, FRR_RESP_OKAY);
        host_u.rewind();
        host_u.hold(8);
        rd(FRR_REG_RD_PTR, 32'h0000_0000, FRR_RESP_OKAY);
        rd(FRR_REG_WR_PTR, 32'h0000_0003, FRR_RESP_OKAY);
        rd(FRR_REG_AE_OFS, 32'h0000_0003, FRR_RESP_OKAY);
        host_u.gate(1'b1);
        got(0, 3);
        host_u.gate(1'b0);
        host_u.o_mark <= 1'b1;
        host_u.hold(6);
        push(2);
        host_u.gate(1'b1);
        got(3, 2);
        host_u.gate(1'b0);
        host_u.rewind();
        host_u.hold(8);
        rd(FRR_REG_RD_PTR, 32'h0000_0003, FRR_RESP_OKAY);
        rd(FRR_REG_STATUS, 32'h0000_0204, FRR_RESP_OKAY);
        chk(empty_n, 1'b1);
        rewind_watch();
        chk(lo, 1'b1);
        wr(FRR_REG_CTRL, 32'h0000_0002, FRR_RESP_OKAY);
        rewind_watch();
        chk(hi, 1'b1);
        rd(FRR_REG_CTRL, 32'h0000_0002, FRR_RESP_OKAY);
        wr(FRR_REG_CTRL, 32'h0000_0000, FRR_RESP_OKAY);
        host_u.o_mark <= 1'b0;
        for (int i = 7; i >= 0; i--) host_u.shift(8'hA5 >> i, 1'b1);
        rd(FRR_REG_AE_OFS, 32'h0000_000A, FRR_RESP_OKAY);
        rd(FRR_REG_AF_OFS, 32'h0000_0005, FRR_RESP_OKAY);
        repeat (4) host_u.shift(1'b1, 1'b0);
        rd(FRR_REG_AE_OFS, 32'h0000_000A, FRR_RESP_OKAY);
        rd(FRR_REG_AF_OFS, 32'h0000_0005, FRR_RESP_OKAY);
        // a partial strobe must leave the offset alone
        wstrb <= 4'h3;
        wr(FRR_REG_AE_OFS, 32'h0000_0007, FRR_RESP_OKAY);
        wstrb <= 4'hF;
        rd(FRR_REG_AE_OFS, 32'h0000_000A, FRR_RESP_OKAY);
        wr(FRR_REG_CTRL, 32'h0000_0001, FRR_RESP_OKAY);
        host_u.gate(1'b1);
        host_u.hold(12);
        chk(host_u.got_q.size(), 0);
        host_u.strobe();
        got(3, 1);
        host_u.gate(1'b0);
        wr(FRR_REG_CTRL, 32'h0000_0000, FRR_RESP_OKAY);
        host_u.stall <= 1'b1;
        host_u.gate(1'b1);
        push(19);
        host_u.hold(20);
        chk(wr_ready, 1'b0);
        chk(rd_valid, 1'b1);
        chk(af_n, 1'b0);
        chk(ae_n, 1'b1);
        rd(FRR_REG_STATUS, 32'h0000_1002, FRR_RESP_OKAY);
        host_u.stall <= 1'b0;
        got(4, 20);
        host_u.hold(6);
        rd(FRR_REG_STATUS, 32'h0000_0001, FRR_RESP_OKAY);
        chk(empty_n, 1'b0);
        chk(ae_n, 1'b0);
        chk(af_n, 1'b1);
        print_verdict();
    end
endmodule
